// ==== hw/udf_pkg.sv ====
// constants for the unknown-destination steering and pause source address registers
package udf_pkg;
	localparam int unsigned UDF_ADDR_W = 8;
	localparam int unsigned UDF_DATA_W = 32;
	localparam int unsigned UDF_REG_W  = 16;
	localparam int unsigned UDF_PORTS  = 3;

	// register indices as printed; byte address is four times the index
	localparam logic [UDF_ADDR_W-1:0] UDF_IDX_GLOBAL_SEVEN = 8'h0E;
	localparam logic [UDF_ADDR_W-1:0] UDF_IDX_PAUSE_HIGH   = 8'h10;
	localparam logic [UDF_ADDR_W-1:0] UDF_IDX_PAUSE_MID    = 8'h12;
	localparam logic [UDF_ADDR_W-1:0] UDF_IDX_PAUSE_LOW    = 8'h14;
	localparam int unsigned           UDF_IDX_SHIFT        = 2;

	// fields of the global control seven register
	localparam int unsigned UDF_STEER_EN_BIT = 7;
	localparam int unsigned UDF_MASK_LSB     = 0;
	localparam int unsigned UDF_MASK_MSB     = 2;

	// reset values and the all-ports mask
	localparam logic                 UDF_STEER_EN_RST = 1'b0;
	localparam logic [UDF_PORTS-1:0] UDF_MASK_RST     = 3'h7;
	localparam logic [UDF_REG_W-1:0] UDF_PAUSE_LOW_RST = 16'hFFFF;
	localparam logic [UDF_PORTS-1:0] UDF_ALL_PORTS    = 3'h7;

	typedef logic [UDF_PORTS-1:0] udf_portmask_t;
endpackage : udf_pkg

// ==== hw/udf_unknown_steer.sv ====
// egress port selection for lookup results, including unknown destinations
`timescale 1ns/1ns
module udf_unknown_steer
	import udf_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  arst_n,
	input  wire logic                  lkValid,
	input  wire logic                  lkMiss,
	input  wire udf_pkg::udf_portmask_t lkHitMask,
	input  wire udf_pkg::udf_portmask_t ingressPort,
	input  wire logic                  steerEnable,
	input  wire udf_pkg::udf_portmask_t defaultMask,
	output      logic                  fwdValid,
	output      udf_pkg::udf_portmask_t fwdMask
);
	import udf_pkg::*;

	udf_portmask_t next_fwdMask;
	udf_portmask_t floodMask;
	udf_portmask_t missMask;

	assign floodMask = UDF_ALL_PORTS & ~ingressPort;
	assign missMask = steerEnable ? defaultMask : floodMask;
	assign next_fwdMask = lkMiss ? missMask : lkHitMask;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fwdValid <= 1'b0;
			fwdMask  <= '0;
		end else begin
			fwdValid <= lkValid;
			if (lkValid) begin
				fwdMask <= next_fwdMask;
			end
		end
	end
endmodule : udf_unknown_steer

// ==== hw/udf_switch_global_cfg.sv ====
// switch global configuration: unknown-destination steering and pause source address
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
module udf_switch_global_cfg
	import udf_pkg::*;
#(
	// reset values of the upper address words; values are arbitrary
	parameter logic [15:0] PAUSE_HIGH_RST = 16'h0200,
	parameter logic [15:0] PAUSE_MID_RST  = 16'h0000
)(
	input  wire logic                          clock,
	input  wire logic                          arst_n,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [udf_pkg::UDF_ADDR_W-1:0] paddr,
	input  wire logic [udf_pkg::UDF_DATA_W-1:0] pwdata,
	input  wire logic [3:0]                    pstrb,
	output      logic [udf_pkg::UDF_DATA_W-1:0] prdata,
	output      logic                          pready,
	output      logic                          pslverr,
	input  wire logic                          lkValid,
	input  wire logic                          lkMiss,
	input  wire udf_pkg::udf_portmask_t         lkHitMask,
	input  wire udf_pkg::udf_portmask_t         ingressPort,
	output      logic                          fwdValid,
	output      udf_pkg::udf_portmask_t         fwdMask,
	output      logic [47:0]                   pauseSrcAddr
);
	import udf_pkg::*;

	function automatic logic [UDF_REG_W-1:0] merge16(
		input logic [UDF_REG_W-1:0]  old,
		input logic [UDF_DATA_W-1:0] wd,
		input logic [3:0]            strb
	);
		logic [UDF_REG_W-1:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction : merge16

	function automatic logic [UDF_ADDR_W-1:0] byteAddr(input logic [UDF_ADDR_W-1:0] idx);
		return UDF_ADDR_W'(idx << UDF_IDX_SHIFT);
	endfunction : byteAddr

	logic                 steerEnable;
	udf_portmask_t        defaultMask;
	logic [UDF_REG_W-1:0] pauseHigh;
	logic [UDF_REG_W-1:0] pauseMid;
	logic [UDF_REG_W-1:0] pauseLow;

	wire logic                  hitSeven;
	wire logic                  hitHigh;
	wire logic                  hitMid;
	wire logic                  hitLow;
	wire logic                  hitAny;
	wire logic                  setupPhase;
	wire logic                  accessPhase;
	wire logic                  wrStrobe;
	wire logic [UDF_REG_W-1:0]  sevenWord;
	wire logic [UDF_REG_W-1:0]  sevenMerged;
	wire logic [UDF_DATA_W-1:0] rdWord;

	// address decode
	assign hitSeven    = (paddr == byteAddr(UDF_IDX_GLOBAL_SEVEN));
	assign hitHigh     = (paddr == byteAddr(UDF_IDX_PAUSE_HIGH));
	assign hitMid      = (paddr == byteAddr(UDF_IDX_PAUSE_MID));
	assign hitLow      = (paddr == byteAddr(UDF_IDX_PAUSE_LOW));
	assign hitAny      = hitSeven | hitHigh | hitMid | hitLow;
	assign setupPhase  = psel & ~penable;
	assign accessPhase = psel & penable;
	assign wrStrobe    = accessPhase & pwrite & hitAny;

	// zero wait states; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = accessPhase & ~hitAny;

	assign sevenWord = {8'h00, steerEnable, 4'h0, defaultMask};
	assign sevenMerged = merge16(sevenWord, pwdata, pstrb);

	assign rdWord = hitSeven ? {16'h0000, sevenWord} :
	                hitHigh  ? {16'h0000, pauseHigh} :
	                hitMid   ? {16'h0000, pauseMid}  :
	                hitLow   ? {16'h0000, pauseLow}  : '0;

	// read data is captured in the setup cycle; no write can land before the access edge
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= '0;
		end else if (setupPhase && !pwrite) begin
			prdata <= rdWord;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			steerEnable <= UDF_STEER_EN_RST;
			defaultMask <= UDF_MASK_RST;
		end else if (wrStrobe && hitSeven) begin
			steerEnable <= sevenMerged[UDF_STEER_EN_BIT];
			defaultMask <= sevenMerged[UDF_MASK_MSB:UDF_MASK_LSB];
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pauseHigh <= PAUSE_HIGH_RST;
		end else if (wrStrobe && hitHigh) begin
			pauseHigh <= merge16(pauseHigh, pwdata, pstrb);
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pauseMid <= PAUSE_MID_RST;
		end else if (wrStrobe && hitMid) begin
			pauseMid <= merge16(pauseMid, pwdata, pstrb);
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pauseLow <= UDF_PAUSE_LOW_RST;
		end else if (wrStrobe && hitLow) begin
			pauseLow <= merge16(pauseLow, pwdata, pstrb);
		end
	end

	assign pauseSrcAddr = {pauseHigh, pauseMid, pauseLow};

	udf_unknown_steer u_steer (
		.clock       (clock),
		.arst_n      (arst_n),
		.lkValid     (lkValid),
		.lkMiss      (lkMiss),
		.lkHitMask   (lkHitMask),
		.ingressPort (ingressPort),
		.steerEnable (steerEnable),
		.defaultMask (defaultMask),
		.fwdValid    (fwdValid),
		.fwdMask     (fwdMask)
	);

	// checks

	logic rstSeen;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rstSeen <= 1'b1;
		end else begin
			rstSeen <= 1'b0;
		end
	end

	property p_steer_default;
		@(posedge clock) disable iff (!arst_n)
		lkValid && lkMiss && steerEnable |=> fwdValid && fwdMask == $past(defaultMask);
	endproperty
	a_steer_default: assert property (p_steer_default)
		else $error("miss with steering on did not use default mask");

	property p_mask_reset;
		@(posedge clock) disable iff (!arst_n)
		rstSeen |-> defaultMask == UDF_ALL_PORTS && pauseLow == UDF_PAUSE_LOW_RST;
	endproperty
	a_mask_reset: assert property (p_mask_reset)
		else $error("mask or low address word not at reset value");

	property p_mask_rw;
		@(posedge clock) disable iff (!arst_n)
		wrStrobe && hitSeven && pstrb[0] |=> defaultMask == $past(pwdata[UDF_MASK_MSB:UDF_MASK_LSB]);
	endproperty
	a_mask_rw: assert property (p_mask_rw)
		else $error("mask differs from written value");

	property p_port3_bit;
		@(posedge clock) disable iff (!arst_n)
		lkValid && lkMiss && steerEnable && !defaultMask[2] |=> !fwdMask[2];
	endproperty
	a_port3_bit: assert property (p_port3_bit)
		else $error("host port selected although its mask bit is clear");

	property p_miss_answered;
		@(posedge clock) disable iff (!arst_n)
		lkValid && lkMiss |=> fwdValid && (fwdMask != 3'h0 || $past(steerEnable));
	endproperty
	a_miss_answered: assert property (p_miss_answered)
		else $error("unknown destination got no egress decision");

	property p_high_write;
		@(posedge clock) disable iff (!arst_n)
		wrStrobe && hitHigh && pstrb[1:0] == 2'h3 |=> pauseSrcAddr[47:32] == $past(pwdata[15:0]);
	endproperty
	a_high_write: assert property (p_high_write)
		else $error("high address word not updated");

	property p_mid_write;
		@(posedge clock) disable iff (!arst_n)
		wrStrobe && hitMid && pstrb[1:0] == 2'h3 |=> pauseSrcAddr[31:16] == $past(pwdata[15:0]);
	endproperty
	a_mid_write: assert property (p_mid_write)
		else $error("mid address word not updated");

	property p_low_stable;
		@(posedge clock) disable iff (!arst_n)
		!(wrStrobe && hitLow) |=> $stable(pauseSrcAddr[15:0]);
	endproperty
	a_low_stable: assert property (p_low_stable)
		else $error("low address word changed without a write");

	property p_flood;
		@(posedge clock) disable iff (!arst_n)
		lkValid && lkMiss && !steerEnable |=> fwdMask == (UDF_ALL_PORTS & ~$past(ingressPort));
	endproperty
	a_flood: assert property (p_flood)
		else $error("flood mask wrong with steering off");

	property p_unmapped_err;
		@(posedge clock) disable iff (!arst_n)
		accessPhase && !hitAny |-> pslverr && pready;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err)
		else $error("unmapped access not flagged");

	property p_mask_read;
		@(posedge clock) disable iff (!arst_n)
		setupPhase && !pwrite && hitSeven |=> prdata[UDF_MASK_MSB:UDF_MASK_LSB] == $past(defaultMask);
	endproperty
	a_mask_read: assert property (p_mask_read)
		else $error("mask read data differs from the register");

	property p_steer_read;
		@(posedge clock) disable iff (!arst_n)
		setupPhase && !pwrite && hitSeven |=> prdata[UDF_STEER_EN_BIT] == $past(steerEnable);
	endproperty
	a_steer_read: assert property (p_steer_read)
		else $error("steer enable read data differs from the register");

	property p_low_write;
		@(posedge clock) disable iff (!arst_n)
		wrStrobe && hitLow && pstrb[1] |=> pauseSrcAddr[15:8] == $past(pwdata[15:8]);
	endproperty
	a_low_write: assert property (p_low_write)
		else $error("low address word not updated");

	property p_strobe_keep;
		@(posedge clock) disable iff (!arst_n)
		wrStrobe && hitMid && !pstrb[1] |=> pauseSrcAddr[31:24] == $past(pauseSrcAddr[31:24]);
	endproperty
	a_strobe_keep: assert property (p_strobe_keep)
		else $error("unstrobed lane of mid address word changed");

	property p_unmapped_quiet;
		@(posedge clock) disable iff (!arst_n)
		accessPhase && pwrite && !hitAny |=> $stable(pauseSrcAddr) && $stable(defaultMask);
	endproperty
	a_unmapped_quiet: assert property (p_unmapped_quiet)
		else $error("unmapped write changed a register");

	property p_unmapped_read;
		@(posedge clock) disable iff (!arst_n)
		setupPhase && !pwrite && !hitAny |=> prdata == '0;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("unmapped read returned nonzero data");

	property p_hit_pass;
		@(posedge clock) disable iff (!arst_n)
		lkValid && !lkMiss |=> fwdValid && fwdMask == $past(lkHitMask);
	endproperty
	a_hit_pass: assert property (p_hit_pass)
		else $error("table hit mask not passed through");

	property p_fwd_pulse;
		@(posedge clock) disable iff (!arst_n)
		!lkValid |=> !fwdValid;
	endproperty
	a_fwd_pulse: assert property (p_fwd_pulse)
		else $error("egress decision without a lookup");

	c_steer_on: cover property (@(posedge clock) disable iff (!arst_n)
		lkValid && lkMiss && steerEnable ##1 fwdValid);
	c_flood: cover property (@(posedge clock) disable iff (!arst_n)
		lkValid && lkMiss && !steerEnable ##1 fwdValid);
	c_low_write: cover property (@(posedge clock) disable iff (!arst_n)
		wrStrobe && hitLow);
	c_bad_addr: cover property (@(posedge clock) disable iff (!arst_n)
		pslverr);
	c_mid_full: cover property (@(posedge clock) disable iff (!arst_n)
		wrStrobe && hitMid && pstrb[1:0] == 2'h3);
endmodule : udf_switch_global_cfg

// ==== bench/test_udf_switch_global_cfg.sv ====
// self-checking bench for the switch global configuration block
`timescale 1ns/1ns
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
	$display("[ERR] t=%0t got %h exp %h", $time, (got), (exp)); end end
module test_udf_switch_global_cfg;
	import udf_pkg::*;
	logic                  clock;
	logic                  arst_n;
	logic                  psel;
	logic                  penable;
	logic                  pwrite;
	logic [UDF_ADDR_W-1:0] paddr;
	logic [UDF_DATA_W-1:0] pwdata;
	logic [3:0]            pstrb;
	logic [UDF_DATA_W-1:0] prdata;
	logic                  pready;
	logic                  pslverr;
	logic                  lkValid;
	logic                  lkMiss;
	udf_portmask_t         lkHitMask;
	udf_portmask_t         ingressPort;
	logic                  fwdValid;
	udf_portmask_t         fwdMask;
	logic [47:0]           pauseSrcAddr;
	int                    mismatches;
	int                    num_checks;
	logic [UDF_DATA_W-1:0] rd;
	logic                  err;

	// reset values of the upper address words handed to the design; values are arbitrary
	localparam logic [15:0] TB_HIGH_RST = 16'h0200;
	localparam logic [15:0] TB_MID_RST  = 16'h0000;
	localparam logic [47:0] TB_ADDR_RST = {TB_HIGH_RST, TB_MID_RST, 16'hFFFF};

	udf_switch_global_cfg #(.PAUSE_HIGH_RST(TB_HIGH_RST), .PAUSE_MID_RST(TB_MID_RST)) u_dut (
		.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lkValid(lkValid), .lkMiss(lkMiss),
		.lkHitMask(lkHitMask), .ingressPort(ingressPort), .fwdValid(fwdValid),
		.fwdMask(fwdMask), .pauseSrcAddr(pauseSrcAddr));

	always #2 clock = ~clock;

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude

	// one apb transfer; byte address is the index shifted by two
	task automatic apb(input logic w, input logic [UDF_ADDR_W-1:0] idx,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= idx << UDF_IDX_SHIFT;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge clock);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge clock);
			if (pready === 1'b1) break;
		end
		if (n == 16) begin
			mismatches++;
			conclude();
		end
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic look(input logic miss, input udf_portmask_t hit, input udf_portmask_t ing,
		input udf_portmask_t exp);
		@(posedge clock);
		lkValid     <= 1'b1;
		lkMiss      <= miss;
		lkHitMask   <= hit;
		ingressPort <= ing;
		@(posedge clock);
		lkValid <= 1'b0;
		#1;
		`CHK(fwdValid, 1'b1)
		`CHK(fwdMask, exp)
		@(posedge clock);
		#1;
		`CHK(fwdValid, 1'b0)
	endtask : look

	task automatic reset_values();
		apb(1'b0, UDF_IDX_GLOBAL_SEVEN, 32'h0, 4'h0);
		`CHK(rd, 32'h0000_0007)
		apb(1'b0, UDF_IDX_PAUSE_LOW, 32'h0, 4'h0);
		`CHK(rd, 32'h0000_FFFF)
		`CHK(pauseSrcAddr, TB_ADDR_RST)
	endtask : reset_values

	task automatic address_words();
		apb(1'b1, UDF_IDX_PAUSE_HIGH, 32'hFFFF_ABCD, 4'hF);
		apb(1'b1, UDF_IDX_PAUSE_MID, 32'h0000_1234, 4'h1);
		apb(1'b1, UDF_IDX_PAUSE_LOW, 32'h0000_5678, 4'h2);
		@(posedge clock);
		#1;
		// word order on the address output
		`CHK(pauseSrcAddr, 48'hABCD_0034_56FF)
		apb(1'b0, UDF_IDX_PAUSE_HIGH, 32'h0, 4'h0);
		`CHK(rd, 32'h0000_ABCD)
		apb(1'b0, UDF_IDX_PAUSE_MID, 32'h0, 4'h0);
		`CHK(rd, 32'h0000_0034)
		apb(1'b0, UDF_IDX_PAUSE_LOW, 32'h0, 4'h0);
		`CHK(rd, 32'h0000_56FF)
		apb(1'b1, UDF_IDX_PAUSE_MID, 32'h0000_2468, 4'h3);
		apb(1'b0, UDF_IDX_PAUSE_MID, 32'h0, 4'h0);
		`CHK(rd, 32'h0000_2468)
		`CHK(pauseSrcAddr, 48'hABCD_2468_56FF)
	endtask : address_words

	task automatic unmapped();
		apb(1'b1, 8'h0F, 32'h0000_FFFF, 4'hF);
		`CHK(err, 1'b1)
		apb(1'b0, 8'h0F, 32'h0, 4'h0);
		`CHK(err, 1'b1)
		`CHK(rd, 32'h0)
		`CHK(pauseSrcAddr, 48'hABCD_2468_56FF)
		apb(1'b0, UDF_IDX_PAUSE_MID, 32'h0, 4'h0);
		`CHK(err, 1'b0)
	endtask : unmapped

	task automatic steering();
		look(1'b1, 3'h0, 3'h1, 3'h6);
		look(1'b1, 3'h5, 3'h4, 3'h3);
		look(1'b0, 3'h5, 3'h1, 3'h5);
		// each mask bit steers to one port
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, UDF_IDX_GLOBAL_SEVEN, 32'h80 | (32'h1 << i), 4'h1);
			apb(1'b0, UDF_IDX_GLOBAL_SEVEN, 32'h0, 4'h0);
			`CHK(rd, 32'h80 | (32'h1 << i))
			look(1'b1, 3'h7, 3'h2, udf_portmask_t'(1 << i));
			look(1'b0, 3'h2, 3'h2, 3'h2);
		end
		// steered miss keeps the ingress port when masked in; a flooded miss with steering off drops it
		apb(1'b1, UDF_IDX_GLOBAL_SEVEN, 32'h0000_FFFF, 4'h1);
		apb(1'b0, UDF_IDX_GLOBAL_SEVEN, 32'h0, 4'h0);
		`CHK(rd, 32'h0000_0087)
		look(1'b1, 3'h0, 3'h4, 3'h7);
		apb(1'b1, UDF_IDX_GLOBAL_SEVEN, 32'h0000_0005, 4'h1);
		look(1'b1, 3'h0, 3'h4, 3'h3);
	endtask : steering

	// reset in mid-run brings every register back to its reset value
	task automatic reset_again();
		@(posedge clock);
		arst_n <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		`CHK(fwdValid, 1'b0)
		`CHK(fwdMask, 3'h0)
		`CHK(pauseSrcAddr, TB_ADDR_RST)
		@(posedge clock);
		arst_n <= 1'b1;
		apb(1'b0, UDF_IDX_GLOBAL_SEVEN, 32'h0, 4'h0);
		`CHK(rd, 32'h0000_0007)
		look(1'b1, 3'h0, 3'h1, 3'h6);
	endtask : reset_again

	initial begin
		clock       = 1'b0;
		arst_n      = 1'b0;
		psel        = 1'b0;
		penable     = 1'b0;
		pwrite      = 1'b0;
		paddr       = '0;
		pwdata      = '0;
		pstrb       = 4'h0;
		lkValid     = 1'b0;
		lkMiss      = 1'b0;
		lkHitMask   = 3'h0;
		ingressPort = 3'h0;
		mismatches  = 0;
		num_checks  = 0;
		repeat (4) @(posedge clock);
		arst_n <= 1'b1;
		reset_values();
		address_words();
		unmapped();
		steering();
		reset_again();
		conclude();
	end
endmodule : test_udf_switch_global_cfg
